// ==== shared/test_sched_map.svh ====
/*
  Constants for the test scheduler and alarm evaluator: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from the checker, the bench and the design file.
*/
`ifndef TEST_SCHED_MAP_SVH
`define TEST_SCHED_MAP_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFF_CTRL        8'h00
`define OFF_DURATION    8'h04
`define OFF_INTERVAL    8'h08
`define OFF_LOG_IVL     8'h0C
`define OFF_COUNTS      8'h10
`define OFF_UPPER_LIM   8'h14
`define OFF_LOWER_LIM   8'h18
`define OFF_LIM_EN      8'h1C
`define OFF_STATUS      8'h20
`define OFF_RESULT_CNT  8'h24
`define OFF_LOG_COUNT   8'h28

// ---------------------------------------------------------------
// Control field positions
// ---------------------------------------------------------------
`define CTRL_START      0
`define CTRL_STOP       1
`define CTRL_CONT       2
`define CTRL_LOG_CONT   3
`define CTRL_STOP_CLEAN 4
`define CTRL_CONFIRM    5
`define CTRL_LOWFLOW_EN 6
`define CTRL_ALT_IF     7
`define CTRL_REMOTE     8
`define CTRL_FMT_LSB    12
`define CTRL_MODE_LSB   16

// ---------------------------------------------------------------
// Fixed values
// ---------------------------------------------------------------
`define MIN_PARTICLES   16'h0014
`define FMT_CLASS       3'h1
`define MODE_WARN_ALARM 3'h0
`define TICKS_PER_SEC   26'h262_5A00
`define RESET_DURATION  16'h0078
`define RESET_INTERVAL  16'h0000
`define RESET_LOG_IVL   16'h0000
`define LIM_EMPTY       8'hFF

`endif

// ==== shared/test_sched_pkg.sv ====
/*
  Types shared by the test scheduler and alarm evaluator.
  Assumes test_sched_map.svh is on the include path.
*/
package test_sched_pkg;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum {st_idle, st_testing, st_waiting} sched_state_e;

  typedef struct packed {
    logic [7:0] code4;
    logic [7:0] code6;
    logic [7:0] code14;
    logic [7:0] water;
    logic [7:0] temp;
  } result_s;

  typedef struct packed {
    logic       out1;
    logic       out2;
    logic [1:0] light;
  } alarm_out_s;

endpackage

// ==== testbench/sched_checker.sv ====
/*
  Port-level assertions for the test scheduler and alarm evaluator.
  Assumes one clock, reset active high, bound onto the top module.
*/
`timescale 1ns/10ps
`include "test_sched_map.svh"

module sched_checker
  import test_sched_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        result_valid,
  input wire logic [15:0] count4,
  input wire logic        remote_port,
  input wire logic        test_run,
  input wire logic        log_strobe,
  input wire logic        machine_alt_if,
  input wire logic        fault,
  input wire alarm_out_s  alarm_out
);
  logic done;
  logic ctrl_wr;
  assign done    = result_valid && test_run;
  assign ctrl_wr = wr && (addr == `OFF_CTRL);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  fault_low_a: assert property (done && count4 < 16'h0014 |-> ##[1:2] fault)
    else $error("fault missing after low count");
  fault_ok_a: assert property (done && count4 >= 16'h0014 |-> ##[1:2] !fault)
    else $error("fault set with enough particles");
  alarm_hold_a: assert property (!$past(done) && !$past(done, 2) |->
    $stable(alarm_out)) else $error("alarm outputs moved between tests");
  fault_hold_a: assert property (!$past(done) && !$past(done, 2) |->
    $stable(fault)) else $error("fault moved between tests");
  log_cause_a: assert property (log_strobe |-> $past(done) || $past(done, 2))
    else $error("log pulse without completed test");
  light_match_a: assert property (alarm_out.out2 == alarm_out.light[1])
    else $error("upper output and light disagree");
  start_run_a: assert property (ctrl_wr && wdata[0] && !wdata[1] |=> test_run)
    else $error("start did not begin a test");
  stop_run_a: assert property (ctrl_wr && wdata[1] && !wdata[0] |=> !test_run)
    else $error("stop did not end testing");
  alt_set_a: assert property (ctrl_wr && wdata[7] |=> machine_alt_if)
    else $error("alternative interface not selected");
  alt_clear_a: assert property ($fell(machine_alt_if) |->
    $past(ctrl_wr && remote_port && !wdata[7]))
    else $error("alternative interface cleared without remote write");

  cover property (done && count4 < 16'h0014);
  cover property (log_strobe);
  cover property ($rose(machine_alt_if));
  cover property (done ##1 test_run);
endmodule

bind test_sched_alarm sched_checker chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .result_valid(result_valid), .count4(count4), .remote_port(remote_port),
  .test_run(test_run), .log_strobe(log_strobe),
  .machine_alt_if(machine_alt_if), .fault(fault), .alarm_out(alarm_out)
);

// ==== testbench/sensor_model.sv ====
/*
  Sensing front end model: delivers one result pulse per request.
  Assumes requests come from the bench; waits for a running test.
*/
`timescale 1ns/10ps

module sensor_model
  import test_sched_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        test_run,
  input  wire logic        fire,
  input  wire logic [3:0]  delay,
  input  wire result_s     res_in,
  input  wire logic [15:0] cnt_in,
  output logic             result_valid,
  output result_s          result,
  output logic [15:0]      count4
);
  logic [3:0] wait_cnt;
  logic       armed;
  logic       emit;
  assign emit = armed && test_run && (wait_cnt == 4'h0) && !fire;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed    <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (fire) begin
      armed    <= 1'b1;
      wait_cnt <= delay;
    end else if (emit) begin
      armed <= 1'b0;
    end else if (armed && test_run && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end

  // Data toggles outside the pulse so stale values never look valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_valid <= 1'b0;
      result       <= '0;
      count4       <= 16'h0000;
    end else begin
      result_valid <= emit;
      result       <= emit ? res_in : ~result;
      count4       <= emit ? cnt_in : ~count4;
    end
  end
endmodule

// ==== testbench/test_scheduler_alarm_eval_tb.sv ====
/*
  Self-checking bench for the test scheduler and alarm evaluator.
  Assumes the sensor model and the bound checker; intervals kept at zero while tests run.
*/
`timescale 1ns/10ps
`include "test_sched_map.svh"

module test_scheduler_alarm_eval_tb
  import test_sched_pkg::*;
;
  logic        clk, rst, wr, rd, remote_port, fire, logged;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d, seed;
  logic [3:0]  delay;
  logic [15:0] cnt_in, count4;
  result_s     res_in, result, cl, dr;
  logic        result_valid, test_run, log_strobe, machine_alt_if, fault;
  alarm_out_s  alarm_out;
  int          fail_count, checks_done;

  test_sched_alarm dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .result_valid(result_valid),
    .result(result), .count4(count4), .remote_port(remote_port),
    .test_run(test_run), .log_strobe(log_strobe),
    .machine_alt_if(machine_alt_if), .fault(fault), .alarm_out(alarm_out));
  sensor_model sens (.clk(clk), .rst(rst), .test_run(test_run), .fire(fire),
    .delay(delay), .res_in(res_in), .cnt_in(cnt_in),
    .result_valid(result_valid), .result(result), .count4(count4));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic over(result_s r, logic [31:0] lim,
                                logic [7:0] tl, logic [2:0] f);
    logic [7:0] m;
    m = r.code4;
    if (f == `FMT_CLASS) begin
      if (r.code6 > m) m = r.code6;
      if (r.code14 > m) m = r.code14;
    end
    return m > lim[31:24] || r.code6 > lim[23:16] ||
           r.code14 > lim[15:8] || r.water > lim[7:0] || r.temp > tl;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_bit(string n, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_alarm(string n, alarm_out_s e, alarm_out_s g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr_reg(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic run_test(result_s r, logic [15:0] c, logic [3:0] dl);
    int n;
    @(posedge clk);
    res_in <= r;
    cnt_in <= c;
    delay  <= dl;
    fire   <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    n = 0;
    logged = 1'b0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (result_valid !== 1'b1 && n < 60);
    if (n >= 60) chk_bit("result pulse", 1'b1, 1'b0);
    repeat (4) begin
      @(posedge clk);
      #1 logged |= (log_strobe === 1'b1);
    end
  endtask

  task automatic eval_case(result_s r, logic [31:0] lu, logic [31:0] ll,
                           logic [7:0] ut, logic [7:0] lt, logic [2:0] f,
                           logic [2:0] m, logic en);
    logic [31:0] rv;
    logic        up, lo;
    rv = next_rand();
    wr_reg(`OFF_UPPER_LIM, lu);
    wr_reg(`OFF_LOWER_LIM, ll);
    wr_reg(`OFF_LIM_EN, {lt, ut, en ? 16'h1f1f : 16'h0000});
    wr_reg(`OFF_CTRL, {13'h0000, m, 1'b0, f, 12'h001});
    run_test(r, 16'h0100, rv[3:0]);
    up = en && over(r, lu, ut, f);
    lo = en && over(r, ll, lt, f);
    chk_alarm("alarm", {(m == 3'h0) ? lo : !lo, up, up, lo}, alarm_out);
  endtask

  task automatic seq(logic [31:0] c, logic [3:0] dirty, logic [3:0] run_e,
                     logic [3:0] log_e);
    wr_reg(`OFF_CTRL, c);
    for (int k = 0; k < 4; k++) begin
      run_test(dirty[k] ? dr : cl, 16'h0100, 4'h0);
      chk_bit("running", run_e[k], test_run);
      chk_bit("logged", log_e[k], logged);
    end
    wr_reg(`OFF_CTRL, 32'h0000_0002);
  endtask

  initial begin
    #(25 * 60000);
    fail_count++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [63:0] w;
    logic [31:0] lu, ll, w2;
    seed = 32'h8c09_5143;
    {rst, wr, rd, remote_port, fire, logged} = 6'b100000;
    {addr, wdata, delay, cnt_in} = '0;
    res_in = '0;
    fail_count = 0;
    checks_done = 0;
    cl = '0;
    dr = {8'h20, 32'h0000_0000};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk_alarm("reset alarm", '0, alarm_out);
    chk_bit("reset run", 1'b0, test_run);
    rd_reg(`OFF_DURATION, d);
    chk_word("duration", {16'h0000, `RESET_DURATION}, d);
    rd_reg(8'h3C, d);
    chk_word("unmapped", 32'h0000_0000, d);
    for (int i = 0; i < 16; i++) begin
      w  = {next_rand(), next_rand()};
      lu = next_rand();
      ll = next_rand();
      w2 = next_rand();
      eval_case(w[39:0], lu, ll, w2[7:0], w2[15:8], 3'(w2[16]),
                3'(w2[18:17]), 1'b1);
    end
    // Equal is not over; one lane over; temperature alone; all empty
    eval_case({5{8'h30}}, 32'h3030_3030, 32'hf0f0_f0f0, 8'h30, 8'hf0,
              3'h0, 3'h0, 1'b1);
    eval_case({8'h30, 8'h31, 24'h303030}, 32'h3030_3030, 32'hf0f0_f0f0,
              8'h30, 8'hf0, 3'h0, 3'h0, 1'b1);
    eval_case({32'h0, 8'h31}, 32'h3030_3030, 32'h2020_2020, 8'h30, 8'h20,
              3'h0, 3'h0, 1'b1);
    eval_case({5{8'hfe}}, 32'h0, 32'h0, 8'h00, 8'h00, 3'h0, 3'h0, 1'b0);
    for (int f = 0; f < 2; f++) begin
      eval_case({8'h05, 8'h00, 8'h11, 16'h0}, 32'h10fe_fefe, 32'hfefe_fefe,
                8'hfe, 8'hfe, 3'(f), 3'(f), 1'b1);
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(`OFF_CTRL, (i == 2) ? 32'h0000_0041 : 32'h0000_0001);
      run_test(cl, (i == 1) ? 16'h0014 : 16'h0013, 4'h3);
      chk_bit("fault", i != 1, fault);
      rd_reg(`OFF_STATUS, d);
      chk_bit("status fault", i != 1, d[1]);
    end
    wr_reg(`OFF_UPPER_LIM, 32'hfefe_fefe);
    wr_reg(`OFF_LOWER_LIM, 32'h1010_1010);
    wr_reg(`OFF_LIM_EN, 32'h10fe_1f1f);
    seq(32'h0000_0005, 4'b1111, 4'b1111, 4'b0000);
    seq(32'h0000_0015, 4'b0111, 4'b0111, 4'b1000);
    wr_reg(`OFF_COUNTS, 32'h0000_0200);
    seq(32'h0000_0035, 4'b0010, 4'b0111, 4'b1000);
    wr_reg(`OFF_COUNTS, 32'h0000_0002);
    seq(32'h0000_000d, 4'b1111, 4'b1111, 4'b1100);
    // 25 single tests, then 0, 1, 1 and 2 from the sequences
    rd_reg(`OFF_LOG_COUNT, d);
    chk_word("log count", 32'h0000_001d, d);
    wr_reg(`OFF_INTERVAL, 32'h0000_0002);
    for (int i = 0; i < 2; i++) begin
      wr_reg(`OFF_LOG_IVL, 32'(3 + i));
      wr_reg(`OFF_CTRL, 32'h0000_0008);
      rd_reg(`OFF_STATUS, d);
      chk_bit("log error", i == 0, d[3]);
    end
    wr_reg(`OFF_CTRL, 32'h0000_0080);
    #1 chk_bit("alt set", 1'b1, machine_alt_if);
    wr_reg(`OFF_CTRL, 32'h0000_0000);
    #1 chk_bit("alt kept", 1'b1, machine_alt_if);
    @(posedge clk);
    remote_port <= 1'b1;
    wr_reg(`OFF_CTRL, 32'h0000_0000);
    #1 chk_bit("alt cleared", 1'b0, machine_alt_if);
    print_verdict();
  end
endmodule

// ==== verilog/test_sched_alarm.sv ====
/*
  Test scheduler and alarm evaluator of an in-line contamination monitor.
  Assumes a sensing front end that pulses result_valid with codes and the
  count of particles above four micrometres at each test end, one 40 MHz
  clock, and a plain register port from software.
*/
// Operation
// - With low-flow alarm off, result valid only with at least 20 particles
// - Under 20 particles raises fault code, whatever the low-flow setting
// - Continuous with interval over duration: new test each interval expiry
// - Continuous with interval under duration: next test starts at once
// - Without continuous logging, only final test of a sequence is logged
// - With continuous logging, log only tests landing on the log interval
// - Error when log interval is not a multiple of the test interval
// - Stop-when-clean repeats tests until clean, then alarms and stops
// - Discard and do not log the configured number of initial tests
// - Confirmation needs consecutive clean results; a dirty one restarts count
// - Alternative machine interface sticks until changed from remote side
// - Two switched outputs and a front light reflect result against limits
// - An alarm is the OR of its cleanliness, water and temperature limits
// - Empty limit is don't-care; all-empty alarm never triggers
// - Limit codes are read according to the selected result format
// - Three-size format compares 4, 6 and 14 micrometre codes and extras
// - Single-class format compares max of size codes as overall class
// - Lettered format compares only the size ranges with a limit entered
// - Alarm mode steers switched outputs only, never the front light
// - Upper limit exceeded only when value strictly greater than limit
// - Mode zero: output one on lower exceeded, output two on upper
`timescale 1ns/10ps
`include "test_sched_map.svh"

module test_sched_alarm
  import test_sched_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        result_valid,
  input  wire result_s     result,
  input  wire logic [15:0] count4,
  input  wire logic        remote_port,
  output logic             test_run,
  output logic             log_strobe,
  output logic             machine_alt_if,
  output logic             fault,
  output alarm_out_s       alarm_out
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0]  ctrl_reg;
  logic [15:0]  duration_reg;
  logic [15:0]  interval_reg;
  logic [15:0]  log_ivl_reg;
  logic [7:0]   ignore_reg;
  logic [7:0]   confirm_reg;
  result_s      upper_reg;
  result_s      lower_reg;
  logic [4:0]   upper_en_reg;
  logic [4:0]   lower_en_reg;
  logic         alt_if_reg;
  sched_state_e state_reg;
  logic [25:0]  tick_reg;
  logic [15:0]  ivl_sec_reg;
  logic [15:0]  log_sec_reg;
  logic [7:0]   ignored_reg;
  logic [7:0]   clean_run_reg;
  logic         clean_hit_reg;
  logic         fault_reg;
  logic [15:0]  log_count_reg;
  logic         log_reg;
  alarm_out_s   out_reg;
  result_s      last_reg;

  logic [2:0]   fmt;
  logic [2:0]   mode;
  logic         sec_tick;
  logic         test_done;
  logic         low_count;
  logic         res_ok;
  logic [7:0]   overall;
  logic [4:0]   up_hit;
  logic [4:0]   lo_hit;
  logic         upper_on;
  logic         lower_on;
  logic         is_clean;
  logic         seq_end;
  logic         log_err;
  logic         start_req;
  logic         stop_req;

  assign fmt       = ctrl_reg[`CTRL_FMT_LSB +: 3];
  assign mode      = ctrl_reg[`CTRL_MODE_LSB +: 3];
  assign start_req = wr && addr == `OFF_CTRL && wdata[`CTRL_START];
  assign stop_req  = wr && addr == `OFF_CTRL && wdata[`CTRL_STOP];
  assign sec_tick  = tick_reg == `TICKS_PER_SEC - 26'h000_0001;
  assign test_done = state_reg == st_testing && result_valid;

  // ---------------------------------------------------------------
  // Result validity
  // ---------------------------------------------------------------
  assign low_count = count4 < `MIN_PARTICLES;
  // Low count faults even with low-flow alarm enabled
  assign res_ok = !low_count;

  // ---------------------------------------------------------------
  // Limit comparison
  // ---------------------------------------------------------------
  // Class format compares the worst size code as the overall class
  always_comb begin
    overall = result.code4;
    if (result.code6 > overall) begin
      overall = result.code6;
    end
    if (result.code14 > overall) begin
      overall = result.code14;
    end
  end

  // Size codes: lane 0..2, water lane 3, temperature lane 4
  always_comb begin
    up_hit = '0;
    lo_hit = '0;
    if (fmt == `FMT_CLASS) begin
      up_hit[0] = upper_en_reg[0] && overall > upper_reg.code4;
      lo_hit[0] = lower_en_reg[0] && overall > lower_reg.code4;
    end else begin
      up_hit[0] = upper_en_reg[0] && result.code4 > upper_reg.code4;
      lo_hit[0] = lower_en_reg[0] && result.code4 > lower_reg.code4;
    end
    // Empty fields carry a clear enable bit, so they never hit
    up_hit[1] = upper_en_reg[1] && result.code6 > upper_reg.code6;
    up_hit[2] = upper_en_reg[2] && result.code14 > upper_reg.code14;
    up_hit[3] = upper_en_reg[3] && result.water > upper_reg.water;
    up_hit[4] = upper_en_reg[4] && result.temp > upper_reg.temp;
    lo_hit[1] = lower_en_reg[1] && result.code6 > lower_reg.code6;
    lo_hit[2] = lower_en_reg[2] && result.code14 > lower_reg.code14;
    lo_hit[3] = lower_en_reg[3] && result.water > lower_reg.water;
    lo_hit[4] = lower_en_reg[4] && result.temp > lower_reg.temp;
  end

  assign upper_on = |up_hit;
  assign lower_on = |lo_hit;
  // Clean target is the lower limit set
  assign is_clean = res_ok && !lower_on;

  // ---------------------------------------------------------------
  // Log interval check
  // ---------------------------------------------------------------
  // Zero test interval means back to back, so any log interval fits
  assign log_err = interval_reg != `RESET_INTERVAL &&
                   (log_ivl_reg % interval_reg) != 16'h0000;

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg     <= '0;
      duration_reg <= `RESET_DURATION;
      interval_reg <= `RESET_INTERVAL;
      log_ivl_reg  <= `RESET_LOG_IVL;
      ignore_reg   <= '0;
      confirm_reg  <= '0;
      upper_reg    <= '0;
      lower_reg    <= '0;
      upper_en_reg <= '0;
      lower_en_reg <= '0;
    end else if (wr) begin
      if (addr == `OFF_CTRL) begin
        ctrl_reg <= wdata & ~32'h0000_0003;
      end else if (addr == `OFF_DURATION) begin
        duration_reg <= wdata[15:0];
      end else if (addr == `OFF_INTERVAL) begin
        interval_reg <= wdata[15:0];
      end else if (addr == `OFF_LOG_IVL) begin
        log_ivl_reg <= wdata[15:0];
      end else if (addr == `OFF_COUNTS) begin
        ignore_reg  <= wdata[7:0];
        confirm_reg <= wdata[15:8];
      end else if (addr == `OFF_UPPER_LIM) begin
        upper_reg <= {wdata[31:0], 8'h00};
      end else if (addr == `OFF_LOWER_LIM) begin
        lower_reg <= {wdata[31:0], 8'h00};
      end else if (addr == `OFF_LIM_EN) begin
        upper_en_reg        <= wdata[4:0];
        lower_en_reg        <= wdata[12:8];
        upper_reg.temp      <= wdata[23:16];
        lower_reg.temp      <= wdata[31:24];
      end
    end
  end

  // Alternative interface sticks; only the remote connector clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alt_if_reg <= 1'b0;
    end else if (wr && addr == `OFF_CTRL) begin
      if (wdata[`CTRL_ALT_IF]) begin
        alt_if_reg <= 1'b1;
      end else if (remote_port) begin
        alt_if_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Scheduler
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_reg <= '0;
    end else if (sec_tick || start_req) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 26'h000_0001;
    end
  end

  // Stop-when-clean ends on target; confirm needs a run of clean tests
  always_comb begin
    seq_end = !ctrl_reg[`CTRL_CONT];
    if (ctrl_reg[`CTRL_STOP_CLEAN] && is_clean) begin
      if (!ctrl_reg[`CTRL_CONFIRM]) begin
        seq_end = 1'b1;
      end else if (clean_run_reg + 8'h01 >= confirm_reg) begin
        seq_end = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg   <= st_idle;
      ivl_sec_reg <= '0;
    end else if (stop_req) begin
      state_reg <= st_idle;
    end else if (start_req) begin
      state_reg   <= st_testing;
      ivl_sec_reg <= '0;
    end else begin
      if (sec_tick) begin
        ivl_sec_reg <= ivl_sec_reg + 16'h0001;
      end
      case (state_reg)
        st_idle: begin
        end
        st_testing: begin
          // Test length is set by the front end's result pulse
          if (test_done) begin
            if (seq_end) begin
              state_reg <= st_idle;
            end else if (interval_reg <= duration_reg) begin
              state_reg   <= st_testing;
              ivl_sec_reg <= '0;
            end else begin
              state_reg <= st_waiting;
            end
          end
        end
        st_waiting: begin
          // Test time counts inside the interval
          if (sec_tick && ivl_sec_reg + 16'h0001 >= interval_reg) begin
            state_reg   <= st_testing;
            ivl_sec_reg <= '0;
          end
        end
        default: begin
          state_reg <= st_idle;
        end
      endcase
    end
  end

  assign test_run = state_reg == st_testing;

  // ---------------------------------------------------------------
  // Evaluation and logging
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clean_run_reg <= '0;
      fault_reg     <= 1'b0;
      clean_hit_reg <= 1'b0;
    end else if (start_req) begin
      clean_run_reg <= '0;
      clean_hit_reg <= 1'b0;
    end else if (test_done) begin
      fault_reg <= low_count;
      if (is_clean) begin
        clean_run_reg <= clean_run_reg + 8'h01;
      end else begin
        clean_run_reg <= '0;
      end
      clean_hit_reg <= ctrl_reg[`CTRL_STOP_CLEAN] && seq_end && is_clean;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ignored_reg   <= '0;
      log_sec_reg   <= '0;
      log_reg       <= 1'b0;
      log_count_reg <= '0;
    end else begin
      log_reg <= 1'b0;
      if (test_done) begin
        if (ignored_reg < ignore_reg) begin
          ignored_reg <= ignored_reg + 8'h01;
        end else if (!ctrl_reg[`CTRL_LOG_CONT]) begin
          log_reg <= seq_end;
        end else if (log_sec_reg + interval_reg >= log_ivl_reg) begin
          log_reg     <= !log_err;
          log_sec_reg <= '0;
        end else begin
          log_sec_reg <= log_sec_reg + interval_reg;
        end
      end
      if (log_reg) begin
        log_count_reg <= log_count_reg + 16'h0001;
      end
    end
  end

  // Light follows limits in every mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_reg  <= '0;
      last_reg <= '0;
    end else if (test_done) begin
      last_reg       <= result;
      out_reg.light  <= {upper_on, lower_on};
      if (mode == `MODE_WARN_ALARM) begin
        out_reg.out1 <= lower_on;
        out_reg.out2 <= upper_on;
      end else begin
        out_reg.out1 <= is_clean;
        out_reg.out2 <= upper_on;
      end
    end
  end

  assign alarm_out      = out_reg;
  assign fault          = fault_reg;
  assign log_strobe     = log_reg;
  assign machine_alt_if = alt_if_reg;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      if (addr == `OFF_CTRL) begin
        rdata <= ctrl_reg;
      end else if (addr == `OFF_DURATION) begin
        rdata <= {16'h0000, duration_reg};
      end else if (addr == `OFF_INTERVAL) begin
        rdata <= {16'h0000, interval_reg};
      end else if (addr == `OFF_LOG_IVL) begin
        rdata <= {16'h0000, log_ivl_reg};
      end else if (addr == `OFF_COUNTS) begin
        rdata <= {16'h0000, confirm_reg, ignore_reg};
      end else if (addr == `OFF_STATUS) begin
        rdata <= {16'h0000, clean_run_reg, out_reg, log_err,
                  clean_hit_reg, fault_reg, test_run};
      end else if (addr == `OFF_RESULT_CNT) begin
        rdata <= last_reg[39:8];
      end else if (addr == `OFF_LOG_COUNT) begin
        rdata <= {16'h0000, log_count_reg};
      end else begin
        rdata <= '0;
      end
    end
  end

endmodule
